// File: common/lcdjp_defines.svh
// register map, field positions, reset values and counts for one line channel
// assumes a 32-bit classic wishbone slave and a sampled-clock datapath
// How it works
// - two control bits put the attenuator in the transmit or receive path
// - two size bits pick a 16 or 32 bit buffer, or bypass it
// - buffer written on the path clock, read on the smoothed clock
// - limit flag set when the buffer is two bits from overflow or underflow
// - reading the limit flag clears the buffer and the flag
// - pattern enable sends 2^23-1 at E3 rate, 2^15-1 at DS3 or STS-1
// - pattern enable also starts the receive pattern checker
// - checker in lock drives the receive negative rail output low
// - checker out of lock sets the loss bit and holds that output high
// - a zero then one on the insert bit injects exactly one bit error
// - each detected bit error pulses that output high for one receive cycle
// - pattern mode forces single-rail data on the receive side, except in digital loop
// - remote and local loop bits pick analog, digital or remote loopback
// - analog loop feeds line output back into the receive input
// - analog loop keeps driving the line, ignores the line input pins
// - digital loop routes transmit clock and rails to the receive outputs
// - remote loop retransmits received data after the attenuator on its clock
// - remote loop ignores the system transmit clock and data
// - all-ones bit sends continuous alternate-mark ones at transmit clock rate
// - all-ones is off in analog and remote loop, works in digital loop
`ifndef LCDJP_DEFINES_SVH
`define LCDJP_DEFINES_SVH

// ==========================================================
// register offsets
`define LCDJP_ADR_CTRL 4'h0
`define LCDJP_ADR_STATUS 4'h4

// ==========================================================
// control bits
`define LCDJP_CB_TXPATH 0
`define LCDJP_CB_RXPATH 1
`define LCDJP_CB_SIZE_LO 2
`define LCDJP_CB_SIZE_HI 3
`define LCDJP_CB_PATTERN 4
`define LCDJP_CB_INSERT 5
`define LCDJP_CB_REMOTE 6
`define LCDJP_CB_LOCAL 7
`define LCDJP_CB_ONES 8
`define LCDJP_CB_E3 9
`define LCDJP_CTRL_RESET 10'h000

// ==========================================================
// status bits
`define LCDJP_SB_LIMIT 0
`define LCDJP_SB_LOSS 1
`define LCDJP_SB_SYNC 2
`define LCDJP_SB_OCC_LSB 8

// ==========================================================
// buffer depths and limits
`define LCDJP_DEPTH_SMALL 6'h10
`define LCDJP_DEPTH_LARGE 6'h20
`define LCDJP_LIMIT_MARGIN 6'h02

// ==========================================================
// pattern sequence taps and lock counts
`define LCDJP_TAP_LONG_A 22
`define LCDJP_TAP_LONG_B 17
`define LCDJP_TAP_SHORT_A 14
`define LCDJP_TAP_SHORT_B 13
`define LCDJP_LFSR_SEED 23'h7f_ffff
`define LCDJP_LOCK_RUN 6'h30
`define LCDJP_LOSS_ERRORS 3'h4

`endif

// File: common/lcdjp_pkg.sv
// types shared by the channel diagnostic and jitter path design
// assumes the defines header is included before use
package lcdjp_pkg;

  typedef enum logic [3:0] {
    LCDJP_LOOP_NONE = 4'b0001,
    LCDJP_LOOP_ANALOG = 4'b0010,
    LCDJP_LOOP_REMOTE = 4'b0100,
    LCDJP_LOOP_DIGITAL = 4'b1000
  } lcdjp_loop_t;

  typedef struct packed {
    logic [31:0][1:0] cells;
    logic [1:0] rd;
  } lcdjp_mem_t;

endpackage : lcdjp_pkg

// File: hw/lcdjp_elastic_mem.sv
// 32-entry two-bit symbol store for the elastic buffer
// assumes write and read strobes are single-cycle pulses on one clock
`timescale 1ns/1ps
module lcdjp_elastic_mem
  import lcdjp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [4:0] waddr, // write index
  input wire logic [1:0] wdata, // symbol in
  input wire logic re, // read strobe
  input wire logic [4:0] raddr, // read index
  output logic [1:0] rdata // symbol out, registered
);

  lcdjp_mem_t s_q;
  lcdjp_mem_t s_d;

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.cells[waddr] = wdata;
    end
    if (re) begin
      s_d.rd = s_q.cells[raddr];
    end
  end

  // no reset: contents are don't-care until the pointers are valid
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rdata = s_q.rd;

endmodule : lcdjp_elastic_mem

// File: hw/lcdjp_channel.sv
// one line channel: attenuator buffer, pattern generator/checker, loops, all-ones
// assumes link clocks are slow against SYS_CLK and are sampled, not used as clocks
`timescale 1ns/1ps
`include "lcdjp_defines.svh"
module lcdjp_channel
  import lcdjp_pkg::*;
(
  input wire logic SYS_CLK, // system clock
  input wire logic RESET, // async reset, high
  input wire logic [3:0] WB_ADR_I, // byte address
  input wire logic [31:0] WB_DAT_I, // write data
  output logic [31:0] WB_DAT_O, // read data
  input wire logic [3:0] WB_SEL_I, // byte lanes
  input wire logic WB_WE_I, // write
  input wire logic WB_STB_I, // strobe
  input wire logic WB_CYC_I, // cycle
  output logic WB_ACK_O, // acknowledge
  input wire logic TRANSMIT_CLOCK_IN, // system transmit clock
  input wire logic TRANSMIT_POS_RAIL, // system transmit positive rail
  input wire logic TRANSMIT_NEG_RAIL, // system transmit negative rail
  input wire logic LINE_RX_CLOCK, // clock recovered from the line
  input wire logic LINE_IN_TIP, // received positive pulse
  input wire logic LINE_IN_RING, // received negative pulse
  input wire logic SMOOTH_CLOCK_IN, // de-jittered clock
  output logic LINE_OUT_TIP, // transmitted positive pulse
  output logic LINE_OUT_RING, // transmitted negative pulse
  output logic LINE_OUT_CLOCK, // transmit timing
  output logic RECOVERED_CLOCK_OUT, // receive clock to system
  output logic RECEIVE_POS_RAIL, // receive positive rail or data
  output logic RX_NEG_RAIL_OR_VIOLATION // receive negative rail or error
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [2:0] prev;
    logic [9:0] ctrl;
    logic ins_prev;
    logic ins_pend;
    logic ack;
    logic [31:0] dat;
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [5:0] occ;
    logic limit;
    logic rd_valid;
    logic [22:0] gen;
    logic tx_pol;
    logic [22:0] chk;
    logic [5:0] good_run;
    logic [2:0] bad_cnt;
    logic in_sync;
    logic line_tip;
    logic line_ring;
    logic line_clk;
    logic line_evt;
    logic rclk;
    logic rpos;
    logic rneg;
  } lcdjp_state_t;

  lcdjp_state_t s_q;
  lcdjp_state_t s_d;
  logic mem_we;
  logic [1:0] mem_wdata;
  logic mem_re;
  logic [1:0] mem_rdata;

  // ==========================================================
  // elastic buffer store
  lcdjp_elastic_mem u_mem (
    .clk(SYS_CLK),
    .we(mem_we),
    .waddr(s_q.wr_ptr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(s_q.rd_ptr),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic tx_clk, tx_pos, tx_neg, rx_clk, rx_tip, rx_ring, dj_clk;
    logic tx_e, rx_e, dj_e;
    logic att_on, tx_att, rx_att, pat, ones, e3;
    lcdjp_loop_t loop;
    logic in_e, rxa_e, src_e, txo_e, wr_e, rd_e, rxa_lvl;
    logic [1:0] in_sym, rxa_sym, src_sym, txo_sym, gen_sym;
    logic [5:0] depth, occ_n;
    logic fb, bit_out, rx_bit, pred, err, rd_status;
    s_d = s_q;
    mem_we = 1'b0;
    mem_wdata = 2'b00;
    mem_re = 1'b0;
    loop = LCDJP_LOOP_NONE;
    gen_sym = 2'b00;
    fb = 1'b0;
    bit_out = 1'b0;
    rx_bit = 1'b0;
    pred = 1'b0;
    err = 1'b0;
    rd_status = 1'b0;
    tx_clk = 1'b0;
    tx_pos = 1'b0;
    tx_neg = 1'b0;
    rx_clk = 1'b0;
    rx_tip = 1'b0;
    rx_ring = 1'b0;
    dj_clk = 1'b0;
    tx_e = 1'b0;
    rx_e = 1'b0;
    dj_e = 1'b0;
    att_on = 1'b0;
    tx_att = 1'b0;
    rx_att = 1'b0;
    pat = 1'b0;
    ones = 1'b0;
    e3 = 1'b0;
    in_e = 1'b0;
    rxa_e = 1'b0;
    src_e = 1'b0;
    txo_e = 1'b0;
    wr_e = 1'b0;
    rd_e = 1'b0;
    rxa_lvl = 1'b0;
    in_sym = 2'b00;
    rxa_sym = 2'b00;
    src_sym = 2'b00;
    txo_sym = 2'b00;
    depth = 6'h00;
    occ_n = 6'h00;

    // pin sampling; only the second stage is read below
    s_d.sync1 = {TRANSMIT_CLOCK_IN, TRANSMIT_POS_RAIL, TRANSMIT_NEG_RAIL,
                 LINE_RX_CLOCK, LINE_IN_TIP, LINE_IN_RING, SMOOTH_CLOCK_IN};
    s_d.sync2 = s_q.sync1;
    {tx_clk, tx_pos, tx_neg, rx_clk, rx_tip, rx_ring, dj_clk} = s_q.sync2;
    s_d.prev = {tx_clk, rx_clk, dj_clk};
    tx_e = tx_clk & ~s_q.prev[2];
    rx_e = rx_clk & ~s_q.prev[1];
    dj_e = dj_clk & ~s_q.prev[0];

    // ==========================================================
    // wishbone slave, one wait state, unmapped reads zero
    if (WB_CYC_I && WB_STB_I && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.dat = 32'h0000_0000;
      if (WB_ADR_I == `LCDJP_ADR_CTRL) begin
        if (WB_WE_I) begin
          if (WB_SEL_I[0]) begin
            s_d.ctrl[7:0] = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            s_d.ctrl[9:8] = WB_DAT_I[9:8];
          end
        end else begin
          s_d.dat[9:0] = s_q.ctrl;
        end
      end else if (WB_ADR_I == `LCDJP_ADR_STATUS && !WB_WE_I) begin
        s_d.dat[`LCDJP_SB_LIMIT] = s_q.limit;
        s_d.dat[`LCDJP_SB_LOSS] = s_q.ctrl[`LCDJP_CB_PATTERN] & ~s_q.in_sync;
        s_d.dat[`LCDJP_SB_SYNC] = s_q.in_sync;
        s_d.dat[`LCDJP_SB_OCC_LSB +: 6] = s_q.occ;
        rd_status = 1'b1;
      end
    end else begin
      s_d.ack = 1'b0;
    end

    // ==========================================================
    // mode decode
    pat = s_q.ctrl[`LCDJP_CB_PATTERN];
    e3 = s_q.ctrl[`LCDJP_CB_E3];
    unique case ({s_q.ctrl[`LCDJP_CB_REMOTE], s_q.ctrl[`LCDJP_CB_LOCAL]})
      2'b01: loop = LCDJP_LOOP_ANALOG;
      2'b10: loop = LCDJP_LOOP_REMOTE;
      2'b11: loop = LCDJP_LOOP_DIGITAL;
      default: loop = LCDJP_LOOP_NONE;
    endcase
    // size code 00 and 11 both bypass
    unique case ({s_q.ctrl[`LCDJP_CB_SIZE_HI], s_q.ctrl[`LCDJP_CB_SIZE_LO]})
      2'b01: depth = `LCDJP_DEPTH_SMALL;
      2'b10: depth = `LCDJP_DEPTH_LARGE;
      default: depth = 6'h00;
    endcase
    att_on = (depth != 6'h00);
    tx_att = att_on & s_q.ctrl[`LCDJP_CB_TXPATH];
    rx_att = att_on & ~s_q.ctrl[`LCDJP_CB_TXPATH] & s_q.ctrl[`LCDJP_CB_RXPATH];
    ones = s_q.ctrl[`LCDJP_CB_ONES] && loop != LCDJP_LOOP_ANALOG
           && loop != LCDJP_LOOP_REMOTE;

    // ==========================================================
    // line input stage; analog loop swaps in our own line output
    if (loop == LCDJP_LOOP_ANALOG) begin
      in_e = s_q.line_evt;
      in_sym = {s_q.line_tip, s_q.line_ring};
    end else begin
      in_e = rx_e;
      in_sym = {rx_tip, rx_ring};
    end
    rxa_e = rx_att ? s_q.rd_valid : in_e;
    rxa_sym = rx_att ? mem_rdata : in_sym;
    rxa_lvl = rx_att ? dj_clk : (loop == LCDJP_LOOP_ANALOG ? s_q.line_clk : rx_clk);

    // ==========================================================
    // transmit source: remote loop, all-ones, pattern or system rails
    fb = e3 ? (s_q.gen[`LCDJP_TAP_LONG_A] ^ s_q.gen[`LCDJP_TAP_LONG_B])
            : (s_q.gen[`LCDJP_TAP_SHORT_A] ^ s_q.gen[`LCDJP_TAP_SHORT_B]);
    bit_out = ones | (fb ^ s_q.ins_pend);
    gen_sym = bit_out ? (s_q.tx_pol ? 2'b01 : 2'b10) : 2'b00;
    if (loop == LCDJP_LOOP_REMOTE) begin
      src_e = rxa_e;
      src_sym = rxa_sym;
    end else begin
      src_e = tx_e;
      src_sym = (ones | pat) ? gen_sym : {tx_pos, tx_neg};
      if (tx_e && (ones || pat)) begin
        s_d.tx_pol = s_q.tx_pol ^ bit_out;
      end
      if (tx_e && pat && !ones) begin
        s_d.gen = {s_q.gen[21:0], fb};
        s_d.ins_pend = 1'b0;
      end
    end
    // one injection per zero-then-one of the insert bit
    if (pat && s_q.ctrl[`LCDJP_CB_INSERT] && !s_q.ins_prev) begin
      s_d.ins_pend = 1'b1;
    end
    s_d.ins_prev = s_q.ctrl[`LCDJP_CB_INSERT];
    if (!pat) begin
      s_d.ins_pend = 1'b0;
      s_d.gen = `LCDJP_LFSR_SEED;
    end
    txo_e = tx_att ? s_q.rd_valid : src_e;
    txo_sym = tx_att ? mem_rdata : src_sym;

    // ==========================================================
    // elastic buffer control
    wr_e = tx_att ? src_e : (rx_att & in_e);
    mem_wdata = tx_att ? src_sym : in_sym;
    rd_e = att_on & dj_e;
    mem_we = wr_e && (s_q.occ != depth);
    mem_re = rd_e && (s_q.occ != 6'h00);
    s_d.rd_valid = mem_re;
    occ_n = s_q.occ + {5'h00, mem_we} - {5'h00, mem_re};
    s_d.occ = occ_n;
    if (mem_we) begin
      s_d.wr_ptr = (s_q.wr_ptr + 5'h01) & 5'(depth - 6'h01);
    end
    if (mem_re) begin
      s_d.rd_ptr = (s_q.rd_ptr + 5'h01) & 5'(depth - 6'h01);
    end
    // clear on status read or while bypassed, then restart at half depth
    if (rd_status || !att_on) begin
      s_d.rd_ptr = 5'h00;
      s_d.wr_ptr = 5'(depth >> 1);
      s_d.occ = depth >> 1;
      s_d.limit = 1'b0;
      s_d.rd_valid = 1'b0;
    end
    // judged on the occupancy left after any clear, so a status read really clears
    if (att_on && (s_d.occ <= `LCDJP_LIMIT_MARGIN
        || s_d.occ >= depth - `LCDJP_LIMIT_MARGIN)) begin
      s_d.limit = 1'b1;
    end

    // ==========================================================
    // line output stage
    s_d.line_evt = txo_e;
    if (txo_e) begin
      {s_d.line_tip, s_d.line_ring} = txo_sym;
    end
    if (tx_att) begin
      s_d.line_clk = dj_clk;
    end else if (loop == LCDJP_LOOP_REMOTE) begin
      s_d.line_clk = rxa_lvl;
    end else begin
      s_d.line_clk = tx_clk;
    end

    // ==========================================================
    // pattern checker, self-synchronising on the received ones
    rx_bit = rxa_sym[1] | rxa_sym[0];
    pred = e3 ? (s_q.chk[`LCDJP_TAP_LONG_A] ^ s_q.chk[`LCDJP_TAP_LONG_B])
              : (s_q.chk[`LCDJP_TAP_SHORT_A] ^ s_q.chk[`LCDJP_TAP_SHORT_B]);
    err = pat && rxa_e && (pred != rx_bit);
    if (!pat) begin
      s_d.chk = 23'h00_0000;
      s_d.good_run = 6'h00;
      s_d.bad_cnt = 3'h0;
      s_d.in_sync = 1'b0;
    end else if (rxa_e) begin
      s_d.chk = {s_q.chk[21:0], rx_bit};
      if (err) begin
        s_d.good_run = 6'h00;
        if (s_q.bad_cnt + 3'h1 >= `LCDJP_LOSS_ERRORS) begin
          s_d.in_sync = 1'b0;
          s_d.bad_cnt = 3'h0;
        end else begin
          s_d.bad_cnt = s_q.bad_cnt + 3'h1;
        end
      end else if (s_q.good_run + 6'h01 >= `LCDJP_LOCK_RUN) begin
        s_d.in_sync = 1'b1;
        s_d.bad_cnt = 3'h0;
        s_d.good_run = 6'h00;
      end else begin
        s_d.good_run = s_q.good_run + 6'h01;
      end
    end

    // ==========================================================
    // receive outputs to the system side
    if (loop == LCDJP_LOOP_DIGITAL) begin
      s_d.rclk = tx_clk;
      s_d.rpos = tx_pos;
      s_d.rneg = tx_neg;
    end else begin
      s_d.rclk = rxa_lvl;
      if (rxa_e) begin
        if (pat) begin
          s_d.rpos = rx_bit;
          // held for one receive period, until the next receive edge
          s_d.rneg = ~s_q.in_sync | err;
        end else begin
          {s_d.rpos, s_d.rneg} = rxa_sym;
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.ctrl <= `LCDJP_CTRL_RESET;
      s_q.gen <= `LCDJP_LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.dat;
  assign LINE_OUT_TIP = s_q.line_tip;
  assign LINE_OUT_RING = s_q.line_ring;
  assign LINE_OUT_CLOCK = s_q.line_clk;
  assign RECOVERED_CLOCK_OUT = s_q.rclk;
  assign RECEIVE_POS_RAIL = s_q.rpos;
  assign RX_NEG_RAIL_OR_VIOLATION = s_q.rneg;

endmodule : lcdjp_channel

// File: tb/lcdjp_channel_assertions.sv
// concurrent checks on the channel's bus, loop and all-ones behaviour
// assumes one SYS_CLK domain; ctrl is shadowed from acked bus writes
`timescale 1ns/1ps
module lcdjp_channel_checker
  import lcdjp_pkg::*;
(
  input wire logic SYS_CLK, // clock
  input wire logic RESET, // reset
  input wire logic [3:0] WB_ADR_I, // address
  input wire logic [31:0] WB_DAT_I, // write data
  input wire logic [31:0] WB_DAT_O, // read data
  input wire logic [3:0] WB_SEL_I, // lanes
  input wire logic WB_WE_I, // write
  input wire logic WB_STB_I, // strobe
  input wire logic WB_CYC_I, // cycle
  input wire logic WB_ACK_O, // ack
  input wire logic TRANSMIT_CLOCK_IN, // tx clock
  input wire logic LINE_RX_CLOCK, // line clock
  input wire logic LINE_OUT_TIP, // line out
  input wire logic LINE_OUT_RING, // line out
  input wire logic LINE_OUT_CLOCK, // tx timing
  input wire logic RECOVERED_CLOCK_OUT // rx clock
);
  logic [9:0] ctrl_q;
  logic [5:0] quiet_q;
  logic st_rd, settled, bypass;
  assign st_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h4;
  // pipelines need a few link bits to flush after a mode change
  assign settled = quiet_q >= 6'h18;
  assign bypass = ctrl_q[3] == ctrl_q[2];
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= 10'h000;
      quiet_q <= 6'h00;
    end else if (WB_ACK_O && WB_WE_I && WB_ADR_I == 4'h0) begin
      ctrl_q[7:0] <= WB_SEL_I[0] ? WB_DAT_I[7:0] : ctrl_q[7:0];
      ctrl_q[9:8] <= WB_SEL_I[1] ? WB_DAT_I[9:8] : ctrl_q[9:8];
      quiet_q <= 6'h00;
    end else if (quiet_q != 6'h3f) begin
      quiet_q <= quiet_q + 6'h01;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked next cycle");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I != 4'h0
    && WB_ADR_I != 4'h4 |-> WB_DAT_O == 32'h0000_0000) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h0 |-> WB_DAT_O == {22'h0, ctrl_q})
    else $error("ctrl readback wrong");
  digital_clk_a: assert property (
    ctrl_q[7:6] == 2'b11 && settled && $rose(TRANSMIT_CLOCK_IN) |-> ##[2:6] RECOVERED_CLOCK_OUT)
    else $error("digital loop clock missing");
  remote_clk_a: assert property (
    ctrl_q[7:6] == 2'b01 && bypass && settled && $rose(LINE_RX_CLOCK) |-> ##[2:6] LINE_OUT_CLOCK)
    else $error("remote loop timing missing");
  ones_ami_a: assert property (
    ctrl_q[8] && ctrl_q[7] == ctrl_q[6] && settled |-> LINE_OUT_TIP ^ LINE_OUT_RING)
    else $error("all-ones not one mark per bit");
  bypass_limit_a: assert property (st_rd && bypass && settled |-> !WB_DAT_O[0])
    else $error("limit set while bypassed");
  pattern_state_a: assert property (
    st_rd && ctrl_q[4] && settled |-> WB_DAT_O[1] != WB_DAT_O[2])
    else $error("loss and sync disagree");
endmodule : lcdjp_channel_checker

bind lcdjp_channel lcdjp_channel_checker u_checker (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I),
  .WB_WE_I(WB_WE_I), .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O),
  .TRANSMIT_CLOCK_IN(TRANSMIT_CLOCK_IN), .LINE_RX_CLOCK(LINE_RX_CLOCK),
  .LINE_OUT_TIP(LINE_OUT_TIP), .LINE_OUT_RING(LINE_OUT_RING),
  .LINE_OUT_CLOCK(LINE_OUT_CLOCK), .RECOVERED_CLOCK_OUT(RECOVERED_CLOCK_OUT));

// File: tb/lcdjp_framer_model.sv
// link source: a gated bit clock of 8 system cycles with two rails
// assumes the system clock; rails move only on the clock's falling side
`timescale 1ns/1ps
module lcdjp_framer_model #(
  parameter logic [15:0] PAT = 16'h000f // pos from bit 0, neg from bit 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // reset
  input wire logic run, // clock runs while high
  output logic lclk, // link clock
  output logic pos, // positive rail
  output logic neg // negative rail
);
  logic [2:0] ph_q;
  logic [15:0] pat_q;
  assign pos = pat_q[0];
  assign neg = pat_q[8];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 3'h0;
      pat_q <= PAT;
      lclk <= 1'b0;
    end else begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) lclk <= run;
      if (ph_q == 3'h3) lclk <= 1'b0;
      // clock stands still when stopped, so no symbol is consumed
      if (ph_q == 3'h3 && lclk) pat_q <= {pat_q[0], pat_q[15:1]};
    end
  end
endmodule : lcdjp_framer_model

// File: tb/lcdjp_channel_bench.sv
// self-checking bench for one line channel
// assumes the framer model drives tx, line and smoothed clocks
`timescale 1ns/1ps
module lcdjp_channel_bench;
  logic clk = 1'b0;
  logic rst;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic tx_run = 1'b1;
  logic line_run = 1'b1;
  logic smooth_run = 1'b1;
  logic sel_line = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rdat;
  logic ack, tx_clk, tx_pos, tx_neg, ln_clk, ln_tip, ln_ring, sm_clk;
  logic out_tip, out_ring, rx_pos, rx_neg;
  wire src_clk = sel_line ? ln_clk : tx_clk;
  wire [1:0] src = sel_line ? {ln_tip, ln_ring} : {tx_pos, tx_neg};
  always #20 clk = ~clk;
  lcdjp_framer_model #(.PAT(16'h000f)) u_tx (.clk(clk), .rst(rst), .run(tx_run),
    .lclk(tx_clk), .pos(tx_pos), .neg(tx_neg));
  lcdjp_framer_model #(.PAT(16'h0033)) u_ln (.clk(clk), .rst(rst), .run(line_run),
    .lclk(ln_clk), .pos(ln_tip), .neg(ln_ring));
  lcdjp_framer_model #(.PAT(16'h0001)) u_sm (.clk(clk), .rst(rst), .run(smooth_run),
    .lclk(sm_clk), .pos(), .neg());
  lcdjp_channel dut (.SYS_CLK(clk), .RESET(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_SEL_I(4'h3), .WB_WE_I(we), .WB_STB_I(cyc), .WB_CYC_I(cyc),
    .WB_ACK_O(ack), .TRANSMIT_CLOCK_IN(tx_clk), .TRANSMIT_POS_RAIL(tx_pos),
    .TRANSMIT_NEG_RAIL(tx_neg), .LINE_RX_CLOCK(ln_clk), .LINE_IN_TIP(ln_tip),
    .LINE_IN_RING(ln_ring), .SMOOTH_CLOCK_IN(sm_clk), .LINE_OUT_TIP(out_tip),
    .LINE_OUT_RING(out_ring), .LINE_OUT_CLOCK(), .RECOVERED_CLOCK_OUT(),
    .RECEIVE_POS_RAIL(rx_pos), .RX_NEG_RAIL_OR_VIOLATION(rx_neg));
  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask : wb
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    wb(4'h0, 1'b0, 32'h0, q);
    chk("ctrl reset", 32'h0, q);
    wb(4'h0, 1'b1, 32'h0000_02c0, q);
    wb(4'h4, 1'b1, 32'hffff_ffff, q);
    wb(4'h0, 1'b0, 32'h0, q);
    chk("ctrl back", 32'h0000_02c0, q);
    wb(4'h8, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask : t_regs
  task automatic t_follow(input logic [31:0] c, input logic ln, input logic lo, input string nm);
    logic [1:0] s;
    logic [31:0] q;
    sel_line = ln;
    wb(4'h0, 1'b1, c, q);
    repeat (40) @(posedge clk);
    repeat (8) begin
      @(posedge src_clk);
      s = src;
      repeat (6) @(posedge clk);
      chk(nm, 32'(s), 32'({rx_pos, rx_neg}));
      if (lo) chk(nm, 32'(s), 32'({out_tip, out_ring}));
    end
  endtask : t_follow
  task automatic t_ones(input logic [31:0] c, input logic ami, input string nm);
    logic [31:0] q;
    int ok;
    logic last;
    ok = 0;
    last = 1'b0;
    wb(4'h0, 1'b1, c, q);
    repeat (40) @(posedge clk);
    repeat (12) begin
      @(posedge tx_clk);
      repeat (6) @(posedge clk);
      if ((out_tip ^ out_ring) === 1'b1 && out_tip !== last) ok++;
      last = out_tip;
    end
    chk(nm, 32'(ami), 32'(ok >= 11));
  endtask : t_ones
  task automatic high(output int h);
    h = 0;
    repeat (600) begin
      @(posedge clk);
      if (rx_neg === 1'b1) h++;
    end
  endtask : high
  task automatic t_prbs(input logic [31:0] c);
    logic [31:0] q;
    int h;
    wb(4'h0, 1'b1, 32'h0, q);
    wb(4'h0, 1'b1, c, q);
    repeat (20) @(posedge clk);
    wb(4'h4, 1'b0, 32'h0, q);
    chk("loss early", 32'h2, q & 32'h6);
    chk("neg early", 32'h1, 32'(rx_neg));
    repeat (900) @(posedge clk);
    wb(4'h4, 1'b0, 32'h0, q);
    chk("sync", 32'h4, q & 32'h6);
    chk("neg locked", 32'h0, 32'(rx_neg));
    wb(4'h0, 1'b1, c | 32'h20, q);
    high(h);
    chk("one insert", 32'd24, 32'(h));
    wb(4'h0, 1'b1, c | 32'h20, q);
    high(h);
    chk("held insert", 32'd0, 32'(h));
    wb(4'h0, 1'b1, c, q);
    wb(4'h0, 1'b1, c | 32'h20, q);
    high(h);
    chk("re-insert", 32'd24, 32'(h));
  endtask : t_prbs
  task automatic t_buf(input logic [31:0] c, input logic under, input logic [31:0] lim,
    input logic [31:0] occ, input logic [31:0] m);
    logic [31:0] q;
    wb(4'h0, 1'b1, c, q);
    repeat (40) @(posedge clk);
    wb(4'h4, 1'b0, 32'h0, q);
    smooth_run <= under;
    line_run <= !under;
    tx_run <= !under;
    repeat (400) @(posedge clk);
    smooth_run <= 1'b0;
    line_run <= 1'b0;
    tx_run <= 1'b0;
    repeat (20) @(posedge clk);
    wb(4'h4, 1'b0, 32'h0, q);
    chk("limit", lim, q & 32'h1);
    wb(4'h4, 1'b0, 32'h0, q);
    chk("cleared", occ << 8, q & m);
    smooth_run <= 1'b1;
    line_run <= 1'b1;
    tx_run <= 1'b1;
  endtask : t_buf
  // ==========================================================
  // main sequence and watchdog
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_follow(32'h0000_00c0, 1'b0, 1'b0, "digital");
    t_follow(32'h0000_0140, 1'b1, 1'b1, "remote");
    t_ones(32'h0000_0100, 1'b1, "ones");
    t_ones(32'h0000_01c0, 1'b1, "ones digital");
    t_ones(32'h0000_0180, 1'b0, "ones analog");
    t_prbs(32'h0000_0090);
    t_prbs(32'h0000_0290);
    t_buf(32'h0000_0006, 1'b0, 32'h1, 32'h8, 32'h3f01);
    t_buf(32'h0000_0006, 1'b1, 32'h1, 32'h8, 32'h3f01);
    t_buf(32'h0000_000a, 1'b0, 32'h1, 32'h10, 32'h3f01);
    t_buf(32'h0000_0005, 1'b0, 32'h1, 32'h8, 32'h3f01);
    t_buf(32'h0000_0002, 1'b0, 32'h0, 32'h0, 32'h1);
    give_verdict();
  end
endmodule : lcdjp_channel_bench
